//--- dhi_pkg.sv
// Purpose: Shared constants and types for the display host port
// Assumes: One 250 MHz core clock, all pins sampled through two flops
// Notes:   Strap codes give the first strap before the second
package dhi_pkg;

    // Host interface modes chosen by the two straps
    typedef enum logic [1:0] {
        DHI_M6800,
        DHI_M8080,
        DHI_MSPI,
        DHI_MI2C
    } dhi_mode_t;

    // Strap codes {mode_strap_a, mode_strap_b}
    localparam logic [1:0] DHI_STRAP_6800 = 2'h1;
    localparam logic [1:0] DHI_STRAP_8080 = 2'h3;
    localparam logic [1:0] DHI_STRAP_SPI  = 2'h0;
    localparam logic [1:0] DHI_STRAP_I2C  = 2'h2;

    // Upper six bits of the I2C slave address; value is arbitrary
    localparam logic [5:0] DHI_I2C_ADDR_HI = 6'h2A;

    // Bit positions on the host bus in serial modes
    localparam int DHI_BIT_SCK  = 0;
    localparam int DHI_BIT_SDI  = 1;
    localparam int DHI_BIT_SDO  = 2;

    // I2C control byte fields
    localparam int DHI_CTL_CONT = 7;
    localparam int DHI_CTL_DC   = 6;

    // Bits in a received byte and reset values
    localparam logic [3:0] DHI_BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] DHI_BUS_RST       = 8'h00;

endpackage : dhi_pkg

//--- dhi_ser_if.sv
// Purpose: Carrier between the port top and the serial byte receiver
// Assumes: All inputs already synchronised to core_clk_in
// Notes:   ctrl modport is the top, rx modport is the receiver
`timescale 1ns/1ps
`default_nettype none
interface dhi_ser_if;
    logic       sck;         // Serial clock level
    logic       sdi;         // Serial data level
    logic       sel;         // Chip selected and not in init
    logic       spi_mode;    // Clocked serial mode
    logic       i2c_mode;    // Two-wire mode
    logic       dc;          // Data/command qualifier level
    logic       byte_valid;  // One-cycle pulse: byte received
    logic [7:0] byte_data;   // Received byte
    logic       byte_is_data;// High for display data
    logic       sda_low;     // Pull SDA low (acknowledge)

    modport ctrl (output sck, sdi, sel, spi_mode, i2c_mode, dc,
                  input  byte_valid, byte_data, byte_is_data, sda_low);
    modport rx   (input  sck, sdi, sel, spi_mode, i2c_mode, dc,
                  output byte_valid, byte_data, byte_is_data, sda_low);
endinterface : dhi_ser_if
`default_nettype wire

//--- dhi_ser_rx.sv
// Purpose: Byte receiver for clocked serial and I2C host modes
// Assumes: Inputs synchronised; serial clock far below core clock
// Notes:   Write-only; I2C reads are not acknowledged
`timescale 1ns/1ps
`default_nettype none
module dhi_ser_rx
    import dhi_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    // Link to the port top
    dhi_ser_if.rx     ser
);

    typedef enum {DHI_IDLE, DHI_ADDR, DHI_CTRL, DHI_DATA} dhi_i2c_st_t;

    dhi_i2c_st_t st, next_st;
    logic [7:0]  shreg, next_shreg;
    logic [3:0]  cnt, next_cnt;
    logic        sck_q, sdi_q, next_sck_q, next_sdi_q;
    logic        acking, next_acking;
    logic        cont, next_cont;
    logic        i2c_dc, next_i2c_dc;
    logic        valid, next_valid;
    logic [7:0]  data, next_data;
    logic        is_data, next_is_data;

    logic rise, fall, start_c, stop_c;

    ////////////////////////////////////////////////////////////////////
    // Edge and bus condition detection on already-synced levels
    assign rise    = ser.sck & ~sck_q;
    assign fall    = ~ser.sck & sck_q;
    assign start_c = ser.i2c_mode & ser.sck & sck_q & sdi_q & ~ser.sdi;
    assign stop_c  = ser.i2c_mode & ser.sck & sck_q & ~sdi_q & ser.sdi;

    // Next-state logic for both serial flavours
    always_comb begin
        next_st      = st;
        next_shreg   = shreg;
        next_cnt     = cnt;
        next_sck_q   = ser.sck;
        next_sdi_q   = ser.sdi;
        next_acking  = acking;
        next_cont    = cont;
        next_i2c_dc  = i2c_dc;
        next_valid   = 1'b0;
        next_data    = data;
        next_is_data = is_data;
        if (!ser.sel) begin
            next_st     = DHI_IDLE;
            next_cnt    = 4'h0;
            next_acking = 1'b0;
        end else if (ser.spi_mode) begin
            // Clock in MSB first on rising edges of bit 0
            if (rise) begin
                next_shreg = {shreg[6:0], ser.sdi};
                if (cnt == DHI_BITS_PER_BYTE - 4'h1) begin
                    next_cnt     = 4'h0;
                    next_valid   = 1'b1;
                    next_data    = {shreg[6:0], ser.sdi};
                    next_is_data = ser.dc;
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
        end else if (ser.i2c_mode) begin
            if (start_c) begin
                next_st     = DHI_ADDR;
                next_cnt    = 4'h0;
                next_acking = 1'b0;
            end else if (stop_c) begin
                next_st     = DHI_IDLE;
                next_acking = 1'b0;
            end else if (rise && cnt < DHI_BITS_PER_BYTE && st != DHI_IDLE) begin
                next_shreg = {shreg[6:0], ser.sdi};
                next_cnt   = cnt + 4'h1;
            end else if (fall && acking) begin
                // Release SDA after the acknowledge clock
                next_acking = 1'b0;
                next_cnt    = 4'h0;
            end else if (fall && cnt == DHI_BITS_PER_BYTE) begin
                next_acking = 1'b1;
                unique case (st)
                    DHI_ADDR: begin
                        // Address low bit comes from the qualifier pin
                        if (shreg == {DHI_I2C_ADDR_HI, ser.dc, 1'b0}) begin
                            next_st = DHI_CTRL;
                        end else begin
                            next_st     = DHI_IDLE;
                            next_acking = 1'b0;
                        end
                    end
                    DHI_CTRL: begin
                        next_cont   = shreg[DHI_CTL_CONT];
                        next_i2c_dc = shreg[DHI_CTL_DC];
                        next_st     = DHI_DATA;
                    end
                    DHI_DATA: begin
                        next_valid   = 1'b1;
                        next_data    = shreg;
                        next_is_data = i2c_dc;
                        next_st      = cont ? DHI_CTRL : DHI_DATA;
                    end
                    DHI_IDLE: begin
                        next_acking = 1'b0;
                    end
                endcase
            end
        end
    end

    // Register stage
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st      <= DHI_IDLE;
            shreg   <= DHI_BUS_RST;
            cnt     <= 4'h0;
            sck_q   <= 1'b0;
            sdi_q   <= 1'b1;
            acking  <= 1'b0;
            cont    <= 1'b0;
            i2c_dc  <= 1'b0;
            valid   <= 1'b0;
            data    <= DHI_BUS_RST;
            is_data <= 1'b0;
        end else begin
            st      <= next_st;
            shreg   <= next_shreg;
            cnt     <= next_cnt;
            sck_q   <= next_sck_q;
            sdi_q   <= next_sdi_q;
            acking  <= next_acking;
            cont    <= next_cont;
            i2c_dc  <= next_i2c_dc;
            valid   <= next_valid;
            data    <= next_data;
            is_data <= next_is_data;
        end
    end

    assign ser.byte_valid   = valid;
    assign ser.byte_data    = data;
    assign ser.byte_is_data = is_data;
    assign ser.sda_low      = acking;

endmodule : dhi_ser_rx
`default_nettype wire

//--- dhi_host_port.sv
// Purpose: Host-facing port of a display controller, four bus modes
// Assumes: Host pins asynchronous; core_clk_in well above pin rates
// Notes:   Mode straps latched only while the reset pin is low
//
// Summary of operation
// - Chip select active low gates all activity.
// - Reset pin low runs initialisation; host holds high.
// - Qualifier high means data, low means command.
// - In I2C, qualifier sets slave address bit.
// - 8080 direction pin is low write strobe.
// - 6800 enable high with select starts cycle.
// - 8080 read strobe low with select reads.
// - Serial: bit0 clock, bit1 data, bit2 open.
// - I2C: bits 2,1 form SDA, bit0 SCL.
// - Parallel modes use 8-bit two-way bus.
`timescale 1ns/1ps
`default_nettype none
module dhi_host_port
    import dhi_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    // Host pins
    input  wire logic       mode_strap_a_in,
    input  wire logic       mode_strap_b_in,
    input  wire logic       chip_sel_n_in,
    input  wire logic       reset_n_in,
    input  wire logic       data_cmd_in,
    input  wire logic       dir_wr_n_in,
    input  wire logic       en_rd_n_in,
    input  wire logic [7:0] host_bus_in,
    output var  logic [7:0] host_bus_out,
    output var  logic [7:0] host_bus_oe_out,
    // Core side
    input  wire logic [7:0] rd_data_in,
    output var  logic       rd_req_out,
    output var  logic       wr_valid_out,
    output var  logic [7:0] wr_data_out,
    output var  logic       wr_is_data_out,
    output var  logic       init_out,
    output var  logic [1:0] mode_out
);

    localparam int SYNC_W = 15;

    logic [SYNC_W-1:0] sync1, sync2;
    logic              s_stra, s_strb, s_cs_n, s_rst_n, s_dc, s_dir, s_en;
    logic [7:0]        s_bus;

    dhi_mode_t  mode, next_mode;
    logic       init, next_init;
    logic       wr_act_q, next_wr_act_q;
    logic       rd_act_q, next_rd_act_q;
    logic [7:0] bus_hold, next_bus_hold;
    logic       dc_hold, next_dc_hold;
    logic       wr_valid, next_wr_valid;
    logic [7:0] wr_data, next_wr_data;
    logic       wr_is_data, next_wr_is_data;
    logic       rd_req, next_rd_req;
    logic [7:0] bus_out, next_bus_out;
    logic [7:0] bus_oe, next_bus_oe;

    logic sel, par_mode, wr_act, rd_act;

    dhi_ser_if ser ();

    ////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers on every host pin
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sync1 <= 15'h0000;
            sync2 <= 15'h0000;
        end else begin
            sync1 <= {mode_strap_a_in, mode_strap_b_in, chip_sel_n_in, reset_n_in,
                      data_cmd_in, dir_wr_n_in, en_rd_n_in, host_bus_in};
            sync2 <= sync1;
        end
    end

    assign {s_stra, s_strb, s_cs_n, s_rst_n, s_dc, s_dir, s_en, s_bus} = sync2;

    ////////////////////////////////////////////////////////////////////
    // Cycle qualification per mode
    assign sel      = ~s_cs_n & ~init;
    assign par_mode = (mode == DHI_M6800) || (mode == DHI_M8080);
    always_comb begin
        wr_act = 1'b0;
        rd_act = 1'b0;
        if (mode == DHI_M6800) begin
            wr_act = sel & s_en & ~s_dir;
            rd_act = sel & s_en & s_dir;
        end else if (mode == DHI_M8080) begin
            wr_act = sel & ~s_dir;
            rd_act = sel & ~s_en & s_dir;
        end
    end

    // Serial receiver hookup; enable pin unused there by design
    assign ser.sck      = s_bus[DHI_BIT_SCK];
    assign ser.sdi      = s_bus[DHI_BIT_SDI];
    assign ser.sel      = sel;
    assign ser.spi_mode = (mode == DHI_MSPI);
    assign ser.i2c_mode = (mode == DHI_MI2C);
    assign ser.dc       = s_dc;

    dhi_ser_rx u_ser_rx (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .ser         (ser)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic for mode, parallel cycles and outputs
    always_comb begin
        next_mode       = mode;
        next_init       = ~s_rst_n;
        next_wr_act_q   = wr_act;
        next_rd_act_q   = rd_act;
        next_bus_hold   = bus_hold;
        next_dc_hold    = dc_hold;
        next_wr_valid   = 1'b0;
        next_wr_data    = wr_data;
        next_wr_is_data = wr_is_data;
        next_rd_req     = 1'b0;
        next_bus_out    = DHI_BUS_RST;
        next_bus_oe     = DHI_BUS_RST;
        if (init) begin
            // Straps assumed static, so latch only during init
            unique case ({s_stra, s_strb})
                DHI_STRAP_6800: next_mode = DHI_M6800;
                DHI_STRAP_8080: next_mode = DHI_M8080;
                DHI_STRAP_SPI:  next_mode = DHI_MSPI;
                DHI_STRAP_I2C:  next_mode = DHI_MI2C;
            endcase
            next_wr_act_q = 1'b0;
            next_rd_act_q = 1'b0;
        end else if (par_mode) begin
            // Track bus while strobe active; commit on trailing edge
            if (wr_act) begin
                next_bus_hold = s_bus;
                next_dc_hold  = s_dc;
            end
            if (wr_act_q && !wr_act) begin
                next_wr_valid   = 1'b1;
                next_wr_data    = bus_hold;
                next_wr_is_data = dc_hold;
            end
            if (rd_act) begin
                next_bus_out = rd_data_in;
                next_bus_oe  = 8'hFF;
            end
            next_rd_req = rd_act & ~rd_act_q;
        end else begin
            if (ser.byte_valid) begin
                next_wr_valid   = 1'b1;
                next_wr_data    = ser.byte_data;
                next_wr_is_data = ser.byte_is_data;
            end
            // Open drain: only ever pull SDA low
            next_bus_oe[DHI_BIT_SDO] = ser.sda_low;
        end
    end

    // Register stage; every output comes from here
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            mode       <= DHI_M6800;
            init       <= 1'b1;
            wr_act_q   <= 1'b0;
            rd_act_q   <= 1'b0;
            bus_hold   <= DHI_BUS_RST;
            dc_hold    <= 1'b0;
            wr_valid   <= 1'b0;
            wr_data    <= DHI_BUS_RST;
            wr_is_data <= 1'b0;
            rd_req     <= 1'b0;
            bus_out    <= DHI_BUS_RST;
            bus_oe     <= DHI_BUS_RST;
        end else begin
            mode       <= next_mode;
            init       <= next_init;
            wr_act_q   <= next_wr_act_q;
            rd_act_q   <= next_rd_act_q;
            bus_hold   <= next_bus_hold;
            dc_hold    <= next_dc_hold;
            wr_valid   <= next_wr_valid;
            wr_data    <= next_wr_data;
            wr_is_data <= next_wr_is_data;
            rd_req     <= next_rd_req;
            bus_out    <= next_bus_out;
            bus_oe     <= next_bus_oe;
        end
    end

    assign host_bus_out    = bus_out;
    assign host_bus_oe_out = bus_oe;
    assign rd_req_out      = rd_req;
    assign wr_valid_out    = wr_valid;
    assign wr_data_out     = wr_data;
    assign wr_is_data_out  = wr_is_data;
    assign init_out        = init;
    assign mode_out        = mode;

endmodule : dhi_host_port
`default_nettype wire

//--- dhi_host_port_asserts.sv
// Purpose: Port checks for the display host port
// Assumes: One clock, synchronous active-high reset
// Notes:   Latencies as set out in the hand-over timing
`timescale 1ns/1ps
`default_nettype none
module dhi_host_port_asserts
    import dhi_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk_in,
    input wire logic       sys_rst_in,
    // Host pins and core inputs
    input wire logic       mode_strap_a_in,
    input wire logic       mode_strap_b_in,
    input wire logic       chip_sel_n_in,
    input wire logic       reset_n_in,
    input wire logic [7:0] rd_data_in,
    // Observed outputs
    input wire logic [7:0] host_bus_out,
    input wire logic [7:0] host_bus_oe_out,
    input wire logic       rd_req_out,
    input wire logic       wr_valid_out,
    input wire logic       init_out,
    input wire logic [1:0] mode_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////
    // Straps steady through a long enough init
    sequence s_strap_hold;
        (init_out && $stable({mode_strap_a_in, mode_strap_b_in}))[*6];
    endsequence
    property p_mode_map;
        s_strap_hold |-> mode_out == {~mode_strap_b_in, mode_strap_a_in};
    endproperty
    a_mode_map: assert property (p_mode_map) else $error("mode vs straps");
    // Mode frozen outside init, so a strap glitch is harmless
    property p_mode_hold;
        (!init_out)[*3] |-> $stable(mode_out);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
    property p_init_on;
        (!reset_n_in)[*4] |-> init_out;
    endproperty
    a_init_on: assert property (p_init_on) else $error("init not set");
    property p_init_off;
        reset_n_in[*4] |-> !init_out;
    endproperty
    a_init_off: assert property (p_init_off) else $error("init stuck");
    property p_cs_gate;
        chip_sel_n_in[*8] |-> !wr_valid_out && !rd_req_out;
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("unselected access");
    property p_wr_pulse;
        wr_valid_out |=> !wr_valid_out;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse long");
    property p_rd_pulse;
        rd_req_out |=> !rd_req_out;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse long");
    property p_rd_drive;
        rd_req_out |-> host_bus_oe_out == 8'hFF && host_bus_out == $past(rd_data_in);
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
    // Serial modes drive nothing but the I2C acknowledge bit
    property p_ser_quiet;
        mode_out[1] |-> host_bus_out == 8'h00 &&
            (host_bus_oe_out & (mode_out[0] ? 8'hFB : 8'hFF)) == 8'h00;
    endproperty
    a_ser_quiet: assert property (p_ser_quiet) else $error("serial drive");
endmodule : dhi_host_port_asserts
bind dhi_host_port dhi_host_port_asserts chk_u (.core_clk_in, .sys_rst_in,
    .mode_strap_a_in, .mode_strap_b_in, .chip_sel_n_in, .reset_n_in, .rd_data_in,
    .host_bus_out, .host_bus_oe_out, .rd_req_out, .wr_valid_out, .init_out, .mode_out);
`default_nettype wire

//--- dhi_host_model.sv
// Purpose: Host controller model driving the display port pins
// Assumes: Called from the bench one small delay after a rising edge
// Notes:   Parallel, clocked serial and I2C writes, parallel reads
`timescale 1ns/1ps
`default_nettype none
module dhi_host_model
    import dhi_pkg::*;
(
    // Clock
    input  wire logic       clk_in,
    // Host pins
    output var  logic       strap_a_out,
    output var  logic       strap_b_out,
    output var  logic       cs_n_out,
    output var  logic       rst_n_out,
    output var  logic       dc_out,
    output var  logic       dir_out,
    output var  logic       en_out,
    output wire logic [7:0] bus_out
);
    logic [7:0] val  = 8'h00;
    logic [7:0] mask = 8'h00;
    logic [7:0] pat  = 8'hA5;
    ////////////////////////////////////////
    // Released bits show a moving pattern, never the last value
    always @(posedge clk_in) pat <= pat + 8'h5B;
    assign bus_out = (val & mask) | (pat & ~mask);
    // Idle pin levels at time zero
    initial begin
        {strap_a_out, strap_b_out, cs_n_out, rst_n_out} = 4'h7;
        {dc_out, dir_out, en_out} = 3'h2;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Straps move only with the reset pin low
    task automatic set_straps(input logic a, b, r);
        strap_a_out = a;
        strap_b_out = b;
        rst_n_out   = r;
        en_out      = a & b; // Read strobe idles high, tied low in serial
        dir_out     = 1'b1;
        cs_n_out    = 1'b1;
    endtask
    task automatic par_wr(input logic m80, c, input logic [7:0] d, input int h,
                          input logic cs);
        cs_n_out = cs;
        dc_out   = c;
        val      = d;
        mask     = 8'hFF;
        dir_out  = 1'b0; // Write direction or write strobe
        if (!m80) en_out = 1'b1;
        tick(h);
        if (m80) dir_out = 1'b1;
        else en_out = 1'b0;
        tick(1);
        cs_n_out = 1'b1;
        mask     = 8'h00;
        dir_out  = 1'b1;
        tick(3);
    endtask
    task automatic par_rd(input logic m80);
        cs_n_out = 1'b0;
        en_out   = !m80; // Direction already high
        tick(5);
        en_out = m80;
        tick(1);
        cs_n_out = 1'b1;
        tick(4);
    endtask
    task automatic ser_wr(input logic c, input logic [7:0] d);
        cs_n_out = 1'b0;
        dc_out   = c;
        mask     = 8'h03; // Bit 2 left open
        for (int i = 7; i >= 0; i--) begin
            val = {6'h00, d[i], 1'b0}; // Clock on bit 0, MSB first
            tick(4);
            val[0] = 1'b1;
            tick(4);
        end
        val[0] = 1'b0;
        tick(4);
        cs_n_out = 1'b1;
        mask     = 8'h00;
        tick(4);
    endtask
    // I2C write: START, address, control, one data byte, STOP; lines idle high
    task automatic i2c_wr(input logic a0, ok, c, input logic [7:0] d);
        logic [7:0] b [3];
        b[0]   = {DHI_I2C_ADDR_HI, a0 ^ ~ok, 1'b0}; // Wrong bit when not ok
        b[1]   = {1'b0, c, 6'h00}; // No continuation, qualifier in bit 6
        b[2]   = d;
        dc_out = a0; // Qualifier pin sets the address bit
        mask   = 8'h03;
        val    = 8'h03;
        tick(6);
        cs_n_out = 1'b0;
        tick(6);
        val[1] = 1'b0; // START: SDA falls while SCL high
        tick(6);
        for (int n = 0; n < 27; n++) begin
            val[0] = 1'b0;
            tick(3);
            // Data moves only while SCL is low; ninth clock lets go for the ack
            if (n % 9 == 8) val[1] = 1'b1;
            else val[1] = b[n / 9][7 - n % 9];
            tick(3);
            val[0] = 1'b1;
            tick(6);
        end
        val[0] = 1'b0;
        tick(3);
        val[1] = 1'b0;
        tick(3);
        val[0] = 1'b1;
        tick(6);
        val[1] = 1'b1; // STOP: SDA rises while SCL high
        tick(6);
        cs_n_out = 1'b1;
        tick(4);
    endtask : i2c_wr
endmodule : dhi_host_model
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the display host port
// Assumes: Host model drives pins; queues hold expected results
// Notes:   I2C writes checked by queue and by a count of acknowledges
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dhi_pkg::*;
    logic       core_clk_in = 1'b0;
    logic       sys_rst_in  = 1'b1;
    logic [7:0] rd_data_in  = 8'h00;
    wire  logic sa, sb, cs_n, rst_n, dc, dir, en;
    wire  logic [7:0] hdrv, bus_lvl, host_bus_out, host_bus_oe_out, wr_data_out;
    wire  logic rd_req_out, wr_valid_out, wr_is_data_out, init_out;
    wire  logic [1:0] mode_out;
    int   error_cnt = 0, n_compared = 0, cyc = 0, seed = 24942;
    logic [8:0] wq[$];
    logic [7:0] rq[$];
    logic [3:0] ack_cnt = 4'h0;
    logic       ack_q   = 1'b0;
    logic [1:0] code [4] = '{DHI_STRAP_6800, DHI_STRAP_8080, DHI_STRAP_SPI, DHI_STRAP_I2C};
    ////////////////////////////////////////
    always #2 core_clk_in = ~core_clk_in;
    // Wire level: device where it drives, host elsewhere
    assign bus_lvl = (host_bus_oe_out & host_bus_out) | (~host_bus_oe_out & hdrv);
    // Board wiring: in two-wire mode bits 2 and 1 form one open-drain SDA line
    wire  logic       i2c_board = sa & ~sb;
    wire  logic       sda       = hdrv[1] & ~host_bus_oe_out[2];
    wire  logic [7:0] pin_lvl   = i2c_board ? {bus_lvl[7:3], sda, sda, bus_lvl[0]} : bus_lvl;
    dhi_host_model host_u (.clk_in(core_clk_in), .strap_a_out(sa), .strap_b_out(sb),
        .cs_n_out(cs_n), .rst_n_out(rst_n), .dc_out(dc), .dir_out(dir), .en_out(en),
        .bus_out(hdrv));
    dhi_host_port dut_u (.core_clk_in, .sys_rst_in, .mode_strap_a_in(sa),
        .mode_strap_b_in(sb), .chip_sel_n_in(cs_n), .reset_n_in(rst_n), .data_cmd_in(dc),
        .dir_wr_n_in(dir), .en_rd_n_in(en), .host_bus_in(pin_lvl), .host_bus_out,
        .host_bus_oe_out, .rd_data_in, .rd_req_out, .wr_valid_out, .wr_data_out,
        .wr_is_data_out, .init_out, .mode_out);
    ////////////////////////////////////////
    task automatic miss(input string m);
        error_cnt++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task automatic cmp_wr(input logic [8:0] e);
        n_compared++;
        if ({wr_is_data_out, wr_data_out} !== e) miss("write byte");
    endtask
    task automatic cmp_rd(input logic [7:0] e);
        n_compared++;
        if (host_bus_out !== e || host_bus_oe_out !== 8'hFF) miss("read byte");
    endtask
    task automatic cmp_st(input logic [2:0] e);
        n_compared++;
        if ({init_out, mode_out} !== e) miss("init or mode");
    endtask
    task automatic cmp_ack(input logic [3:0] e);
        n_compared++;
        if (ack_cnt !== e) miss("ack count");
    endtask : cmp_ack
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Results popped as they appear; strays count as mismatches
    always @(negedge core_clk_in) begin
        if (wr_valid_out === 1'b1) begin
            if (wq.size() == 0) miss("stray write");
            else cmp_wr(wq.pop_front());
        end
        if (rd_req_out === 1'b1) begin
            if (rq.size() == 0) miss("stray read");
            else cmp_rd(rq.pop_front());
        end
        // Count acknowledge pulls on the tied SDA pair
        if (i2c_board && host_bus_oe_out[2] === 1'b1 && !ack_q) ack_cnt = ack_cnt + 4'h1;
        ack_q = (host_bus_oe_out[2] === 1'b1);
    end
    // Run needs about 1500 cycles
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 6000) begin
            miss("timeout");
            wrap_up();
        end
    end
    ////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic       c;
        repeat (16) @(posedge core_clk_in);
        #1 sys_rst_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            host_u.set_straps(code[i][1], code[i][0], 1'b0);
            host_u.tick(12);
            cmp_st({1'b1, ~code[i][0], code[i][1]});
            host_u.set_straps(code[i][1], code[i][0], 1'b1);
            host_u.tick(6);
            cmp_st({1'b0, ~code[i][0], code[i][1]});
            for (int k = 0; k < 3; k++) begin
                d = 8'($random(seed));
                c = (i == 3) ? ~k[1] : k[0];
                if (i != 3 || k != 1) wq.push_back({c, d});
                if (i == 3) host_u.i2c_wr(k[1], k != 1, c, d); // k=1 misaddressed
                else if (i == 2) host_u.ser_wr(c, d);
                else host_u.par_wr(i == 1, c, d, 2 + 2 * k, 1'b0);
            end
            if (i == 3) cmp_ack(4'h6);
            if (i < 2) begin
                rd_data_in = 8'($random(seed));
                rq.push_back(rd_data_in);
                host_u.par_rd(i == 1);
                host_u.par_wr(i == 1, 1'b1, d, 3, 1'b1); // Unselected, ignored
            end
            host_u.tick(10);
            $display("test mode %0d done", i);
        end
        if (wq.size() != 0 || rq.size() != 0) miss("missing result");
        wrap_up();
    end
endmodule : tb
`default_nettype wire
